/* File: rtl/mmu_pkg.sv */
// Shared constants, types and helpers for the translation unit
package mmu_pkg;

  // Translation buffer geometry
  localparam int TLB_ENTRIES = 8;
  localparam int TLB_IDX_W   = 3;

  // Address space identifiers
  localparam logic [7:0] ASI_TLB_FIELD  = 8'h06;
  localparam logic [7:0] ASI_USER_INSN  = 8'h08;
  localparam logic [7:0] ASI_SUPER_INSN = 8'h09;
  localparam logic [7:0] ASI_USER_DATA  = 8'h0a;
  localparam logic [7:0] ASI_SUPER_DATA = 8'h0b;

  // Level match codes, top bit is the valid bit
  localparam logic [2:0] LEVEL_NONE   = 3'h0;
  localparam logic [2:0] LEVEL_IDX1   = 3'h4;
  localparam logic [2:0] LEVEL_IDX12  = 3'h6;
  localparam logic [2:0] LEVEL_IDX123 = 3'h7;

  // Entry type codes
  localparam logic [1:0] ET_INVALID  = 2'h0;
  localparam logic [1:0] ET_POINTER  = 2'h1;
  localparam logic [1:0] ET_PAGE     = 2'h2;
  localparam logic [1:0] ET_RESERVED = 2'h3;

  // Table word field positions
  localparam int PPN_HI     = 26;
  localparam int PPN_LO     = 8;
  localparam int CACHE_BIT  = 7;
  localparam int MOD_BIT    = 6;
  localparam int REF_BIT    = 5;
  localparam int PERM_HI    = 4;
  localparam int PERM_LO    = 2;
  localparam int ET_HI      = 1;
  localparam int ET_LO      = 0;
  localparam int PTR_HI     = 26;
  localparam int PTR_LO     = 4;
  localparam int IO_WR_BIT  = 2;
  localparam int IO_VAL_BIT = 1;
  localparam int FIELD_HI   = 26;
  localparam int FIELD_LO   = 2;
  localparam int FIELD_W    = 25;
  localparam int PA_W       = 31;
  localparam int CTX_W      = 6;
  localparam int WORD_SHIFT = 2;
  localparam int PTR_SHIFT  = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_CTX_PTR    = 8'h04;
  localparam logic [7:0] REG_CONTEXT    = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h0c;
  localparam logic [7:0] REG_FAULT_ADDR = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FLUSH_BIT  = 1;

  // Fault kinds
  typedef enum logic [1:0] {FAULT_NONE, FAULT_INVALID, FAULT_PROTECT} fault_t;

  // One translation buffer entry
  typedef struct packed {
    logic [19:0]        vtag;
    logic [CTX_W-1:0]   ctx;
    logic               sup;
    logic               mod;
    logic               ioN;
    logic               table_pointer_entry;
    logic [2:0]         level;
    logic [5:0]         prot;
    logic [FIELD_W-1:0] phys;
  } tlb_entry_t;

  // Integer unit request and answer
  typedef struct packed {
    logic [31:0] va;
    logic [7:0]  address_space_identifier;
    logic        write;
    logic [31:0] wdata;
  } iu_req_t;

  typedef struct packed {
    logic [PA_W-1:0] paddr;
    logic [31:0]     rdata;
    logic            fault;
    fault_t          kind;
  } iu_resp_t;

  // Permission code to {ur,uw,ux,sr,sw,sx}
  function automatic logic [5:0] perm_decode(input logic [2:0] code);
    case (code)
      3'h0:    perm_decode = 6'h24;
      3'h1:    perm_decode = 6'h36;
      3'h2:    perm_decode = 6'h2d;
      3'h3:    perm_decode = 6'h3f;
      3'h4:    perm_decode = 6'h09;
      3'h5:    perm_decode = 6'h21;
      3'h6:    perm_decode = 6'h05;
      default: perm_decode = 6'h07;
    endcase
  endfunction

  // Physical address from page number, virtual address and level
  function automatic logic [PA_W-1:0] form_paddr(input logic [18:0] physical_page_number, input logic [31:0] va,
                                                 input logic [1:0] lvl);
    case (lvl)
      2'h0:    form_paddr = va[PA_W-1:0];
      2'h1:    form_paddr = {physical_page_number[18:12], va[23:0]};
      2'h2:    form_paddr = {physical_page_number[18:6], va[17:0]};
      default: form_paddr = {physical_page_number, va[11:0]};
    endcase
  endfunction

endpackage

/* File: rtl/tlb_entry_match.sv */
// Tag and context compare for one translation buffer entry
`timescale 1ns/1ps
`default_nettype none
module tlb_entry_match (
  // Entry under test
  input  wire mmu_pkg::tlb_entry_t entry,
  // Access
  input  wire logic [31:0]         va,
  input  wire logic [5:0]          ctx,
  input  wire logic                supervisor,
  // Result
  output logic                     hit
);
  logic levelOk;
  logic ctxOk;

  // Index compares as far as the level field asks
  assign levelOk = entry.level[2] && (entry.vtag[19:12] == va[31:24]) &&
                   (!entry.level[1] || entry.vtag[11:6] == va[23:18]) &&
                   (!entry.level[0] || entry.vtag[5:0] == va[17:12]);
  assign ctxOk   = (entry.ctx == ctx) || (entry.sup && supervisor);
  // Only page entries translate
  assign hit     = levelOk && ctxOk && entry.ioN && !entry.table_pointer_entry;
endmodule
`default_nettype wire

/* File: rtl/mmu_tlb_tablewalk.sv */
// Translation buffer, table walker and register slave
`timescale 1ns/1ps
`default_nettype none
module mmu_tlb_tablewalk (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // AHB-Lite register slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Integer unit requests
  input  wire logic              iuReqValid,
  input  wire mmu_pkg::iu_req_t  iuReq,
  output logic                   iuReqReady,
  output logic                   iuRespValid,
  output mmu_pkg::iu_resp_t      iuResp,
  // Table fetches from main memory
  output logic                   memReq,
  output logic [30:0]            memAddr,
  input  wire logic              memRdValid,
  input  wire logic [31:0]       memRdData
);
  typedef enum {S_IDLE, S_LOOKUP, S_FETCH, S_DONE} walk_state_t;

  walk_state_t                      state;
  mmu_pkg::tlb_entry_t              tlb [mmu_pkg::TLB_ENTRIES];
  mmu_pkg::iu_req_t                 cur;
  logic [mmu_pkg::TLB_ENTRIES-1:0]  hitVec;
  logic [mmu_pkg::TLB_IDX_W-1:0]    hitIdx;
  logic                             anyHit;
  logic [mmu_pkg::TLB_IDX_W-1:0]    victim;
  logic [mmu_pkg::TLB_IDX_W-1:0]    freeIdx;
  logic                             anyFree;
  logic [mmu_pkg::TLB_IDX_W-1:0]    rrPtr;
  logic [1:0]                       walkLevel;
  logic                             isSuper;
  logic                             isInsn;
  logic                             isField;
  logic [5:0]                       hitProt;
  logic                             permOk;
  logic [1:0]                       fetchType;
  logic [2:0]                       fetchPerm;
  logic                             storePage;
  logic                             walkFault;
  logic [30:0]                      nextTable;
  logic [mmu_pkg::TLB_IDX_W-1:0]    fieldIdx;
  // Register file
  logic                             enable;
  logic [30:0]                      ctxPtr;
  logic [mmu_pkg::CTX_W-1:0]        ctxNum;
  mmu_pkg::fault_t                  lastFault;
  logic [31:0]                      faultAddr;
  // Bus data phase
  logic                             dpWrite;
  logic                             dpRead;
  logic                             dpReadWait;
  logic [7:0]                       dpAddr;
  logic                             flushReq;

  // Access classification from the identifier
  assign isSuper = cur.address_space_identifier[0];
  assign isInsn  = (cur.address_space_identifier == mmu_pkg::ASI_USER_INSN) || (cur.address_space_identifier == mmu_pkg::ASI_SUPER_INSN);
  assign isField = (cur.address_space_identifier == mmu_pkg::ASI_TLB_FIELD);
  assign fieldIdx = cur.va[mmu_pkg::TLB_IDX_W+mmu_pkg::WORD_SHIFT-1:mmu_pkg::WORD_SHIFT];

  // Compare every entry in parallel
  genvar gi;
  generate
    for (gi = 0; gi < mmu_pkg::TLB_ENTRIES; gi++) begin : g_match
      tlb_entry_match u_match (
        .entry      (tlb[gi]),
        .va         (cur.va),
        .ctx        (ctxNum),
        .supervisor (isSuper),
        .hit        (hitVec[gi])
      );
    end
  endgenerate

  // Hit index and first free slot
  always_comb begin
    hitIdx  = '0;
    freeIdx = '0;
    anyFree = 1'b0;
    for (int i = mmu_pkg::TLB_ENTRIES - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        hitIdx = i[mmu_pkg::TLB_IDX_W-1:0];
      end
      if (!tlb[i].level[2]) begin
        freeIdx = i[mmu_pkg::TLB_IDX_W-1:0];
        anyFree = 1'b1;
      end
    end
  end
  assign anyHit = |hitVec;
  assign victim = anyFree ? freeIdx : rrPtr;

  // Protection check of the hit entry
  assign hitProt = tlb[hitIdx].prot;
  always_comb begin
    if (isInsn) begin
      permOk = isSuper ? hitProt[0] : hitProt[3];
    end else if (cur.write) begin
      permOk = isSuper ? hitProt[1] : hitProt[4];
    end else begin
      permOk = isSuper ? hitProt[2] : hitProt[5];
    end
  end

  // Decode of the fetched table word
  assign fetchType = memRdData[mmu_pkg::ET_HI:mmu_pkg::ET_LO];
  assign fetchPerm = memRdData[mmu_pkg::PERM_HI:mmu_pkg::PERM_LO];
  assign storePage = memRdValid && fetchType == mmu_pkg::ET_PAGE && walkLevel != 2'h0;
  assign walkFault = memRdValid && (fetchType == mmu_pkg::ET_INVALID || fetchType == mmu_pkg::ET_RESERVED ||
                     (fetchType == mmu_pkg::ET_POINTER && walkLevel == 2'h3));
  assign nextTable = {memRdData[mmu_pkg::PTR_HI:mmu_pkg::PTR_LO], 8'h00};

  // Request handshake
  assign iuReqReady = (state == S_IDLE);

  // Walk and lookup sequence
  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= S_IDLE;
      walkLevel <= 2'h0;
      memReq    <= 1'b0;
      memAddr   <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (iuReqValid) begin
            state <= S_LOOKUP;
          end
        end
        S_LOOKUP: begin
          if (!enable || isField || anyHit) begin
            state <= S_DONE;
          end else begin
            state     <= S_FETCH;
            walkLevel <= 2'h0;
            memReq    <= 1'b1;
            memAddr   <= ctxPtr + {23'h0, ctxNum, 2'h0};
          end
        end
        S_FETCH: begin
          if (memRdValid) begin
            if (fetchType == mmu_pkg::ET_POINTER && walkLevel != 2'h3) begin
              walkLevel <= walkLevel + 2'h1;
              case (walkLevel)
                2'h0:    memAddr <= nextTable | {21'h0, cur.va[31:24], 2'h0};
                2'h1:    memAddr <= nextTable | {23'h0, cur.va[23:18], 2'h0};
                default: memAddr <= nextTable | {23'h0, cur.va[17:12], 2'h0};
              endcase
            end else begin
              memReq <= 1'b0;
              state  <= S_DONE;
            end
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Latch the request under service
  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
    end else if (iuReqValid && iuReqReady) begin
      cur <= iuReq;
    end
  end

  // Answer to the integer unit
  always_ff @(posedge clock) begin
    if (srst) begin
      iuRespValid <= 1'b0;
      iuResp      <= '0;
    end else begin
      iuRespValid <= 1'b0;
      if (state == S_LOOKUP && (!enable || isField || anyHit)) begin
        iuRespValid  <= 1'b1;
        iuResp.rdata <= isField ? {7'h0, tlb[fieldIdx].phys} : 32'h0;
        iuResp.fault <= enable && !isField && !permOk;
        iuResp.kind  <= (enable && !isField && !permOk) ? mmu_pkg::FAULT_PROTECT : mmu_pkg::FAULT_NONE;
        if (!enable || isField) begin
          iuResp.paddr <= cur.va[mmu_pkg::PA_W-1:0];
        end else begin
          iuResp.paddr <= mmu_pkg::form_paddr(tlb[hitIdx].phys[24:6], cur.va,
                                              {1'b0, tlb[hitIdx].level[1]} + {1'b0, tlb[hitIdx].level[0]} +
                                              2'h1);
        end
      end else if (state == S_FETCH && memRdValid && (walkFault || fetchType == mmu_pkg::ET_PAGE)) begin
        iuRespValid  <= 1'b1;
        iuResp.rdata <= 32'h0;
        if (walkFault) begin
          iuResp.fault <= 1'b1;
          iuResp.kind  <= mmu_pkg::FAULT_INVALID;
          iuResp.paddr <= '0;
        end else begin
          iuResp.fault <= !permCheck(mmu_pkg::perm_decode(fetchPerm));
          iuResp.kind  <= permCheck(mmu_pkg::perm_decode(fetchPerm)) ? mmu_pkg::FAULT_NONE : mmu_pkg::FAULT_PROTECT;
          iuResp.paddr <= mmu_pkg::form_paddr(memRdData[mmu_pkg::PPN_HI:mmu_pkg::PPN_LO], cur.va,
                                              walkLevel);
        end
      end
    end
  end

  // Permission check against a decoded set
  function automatic logic permCheck(input logic [5:0] p);
    if (isInsn) begin
      permCheck = isSuper ? p[0] : p[3];
    end else if (cur.write) begin
      permCheck = isSuper ? p[1] : p[4];
    end else begin
      permCheck = isSuper ? p[2] : p[5];
    end
  endfunction

  // Translation buffer contents; a store in the flush cycle survives
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < mmu_pkg::TLB_ENTRIES; i++) begin
        tlb[i] <= '0;
      end
      rrPtr <= '0;
    end else begin
      if (flushReq) begin
        for (int i = 0; i < mmu_pkg::TLB_ENTRIES; i++) begin
          tlb[i].level <= mmu_pkg::LEVEL_NONE;
        end
      end
      if (state == S_LOOKUP && isField && cur.write) begin
        tlb[fieldIdx].phys <= cur.wdata[mmu_pkg::FIELD_W-1:0];
      end else if (state == S_LOOKUP && enable && !isField && anyHit && permOk && cur.write && !isInsn) begin
        tlb[hitIdx].mod <= 1'b1;
        tlb[hitIdx].phys[mmu_pkg::MOD_BIT-mmu_pkg::FIELD_LO] <= 1'b1;
      end else if (state == S_FETCH && storePage) begin
        tlb[victim].vtag  <= cur.va[31:12];
        tlb[victim].ctx   <= ctxNum;
        tlb[victim].sup   <= fetchPerm[2] && fetchPerm[1];
        tlb[victim].mod   <= memRdData[mmu_pkg::MOD_BIT] || (cur.write && !isInsn);
        tlb[victim].ioN   <= 1'b1;
        tlb[victim].table_pointer_entry   <= 1'b0;
        tlb[victim].prot  <= mmu_pkg::perm_decode(fetchPerm);
        tlb[victim].phys  <= {memRdData[mmu_pkg::PPN_HI:mmu_pkg::CACHE_BIT],
                              memRdData[mmu_pkg::MOD_BIT] || (cur.write && !isInsn), 1'b1,
                              fetchPerm};
        case (walkLevel)
          2'h1:    tlb[victim].level <= mmu_pkg::LEVEL_IDX1;
          2'h2:    tlb[victim].level <= mmu_pkg::LEVEL_IDX12;
          default: tlb[victim].level <= mmu_pkg::LEVEL_IDX123;
        endcase
        if (!anyFree) begin
          rrPtr <= rrPtr + mmu_pkg::TLB_IDX_W'(1);
        end
      end
    end
  end
  // Fault capture for software
  always_ff @(posedge clock) begin
    if (srst) begin
      lastFault <= mmu_pkg::FAULT_NONE;
      faultAddr <= '0;
    end else if (iuRespValid && iuResp.fault) begin
      lastFault <= iuResp.kind;
      faultAddr <= cur.va;
    end
  end
  // Bus address phase capture
  always_ff @(posedge clock) begin
    if (srst) begin
      dpWrite    <= 1'b0;
      dpRead     <= 1'b0;
      dpReadWait <= 1'b0;
      dpAddr     <= '0;
    end else begin
      if (hready) begin
        dpWrite    <= hsel && htrans[1] && hwrite;
        dpRead     <= hsel && htrans[1] && !hwrite;
        dpReadWait <= hsel && htrans[1] && !hwrite;
        dpAddr     <= haddr[7:0];
      end else begin
        dpReadWait <= 1'b0;
      end
    end
  end

  // One wait state on reads, always OKAY
  assign hreadyout = !dpReadWait;
  assign hresp     = 1'b0;

  // Register writes
  always_ff @(posedge clock) begin
    if (srst) begin
      enable   <= 1'b0;
      ctxPtr   <= '0;
      ctxNum   <= '0;
      flushReq <= 1'b0;
    end else begin
      flushReq <= 1'b0;
      if (dpWrite) begin
        case (dpAddr)
          mmu_pkg::REG_CTRL: begin
            enable   <= hwdata[mmu_pkg::CTRL_ENABLE_BIT];
            flushReq <= hwdata[mmu_pkg::CTRL_FLUSH_BIT];
          end
          mmu_pkg::REG_CTX_PTR: ctxPtr <= {hwdata[30:2], 2'h0};
          mmu_pkg::REG_CONTEXT: ctxNum <= hwdata[mmu_pkg::CTX_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Register reads during the wait state
  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata <= '0;
    end else if (dpRead && dpReadWait) begin
      case (dpAddr)
        mmu_pkg::REG_CTRL:       hrdata <= {31'h0, enable};
        mmu_pkg::REG_CTX_PTR:    hrdata <= {1'b0, ctxPtr};
        mmu_pkg::REG_CONTEXT:    hrdata <= {26'h0, ctxNum};
        mmu_pkg::REG_STATUS:     hrdata <= {26'h0, rrPtr, lastFault, state == S_FETCH};
        mmu_pkg::REG_FAULT_ADDR: hrdata <= faultAddr;
        default:                 hrdata <= 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: dv/mmu_tlb_tablewalk_asserts.sv */
// Port-level timing checker for the translation unit
`timescale 1ns/1ps
`default_nettype none
module mmu_tlb_tablewalk_asserts (
  // Clock and reset
  input wire logic              clock,
  input wire logic              srst,
  // Register bus
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Integer unit side
  input wire logic              iuReqValid,
  input wire mmu_pkg::iu_req_t  iuReq,
  input wire logic              iuReqReady,
  input wire logic              iuRespValid,
  input wire mmu_pkg::iu_resp_t iuResp,
  // Table fetches
  input wire logic              memReq,
  input wire logic [30:0]       memAddr,
  input wire logic              memRdValid
);
  logic [31:0] vaHeld;
  logic        accept;
  logic        busCmd;

  // Handshake terms
  assign accept = iuReqValid && iuReqReady;
  assign busCmd = hsel && htrans[1] && hready;

  // Address of the request in flight
  always_ff @(posedge clock) begin
    if (srst) begin
      vaHeld <= 32'h0;
    end else if (accept) begin
      vaHeld <= iuReq.va;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
  a_read_wait: assert property (busCmd && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (busCmd && hwrite |=> hreadyout) else $error("write stalled");
  a_ready_busy: assert property (accept |=> !iuReqReady [*2]) else $error("ready while busy");
  a_answer_bound: assert property (accept |-> ##[2:80] iuRespValid) else $error("no answer");
  a_resp_pulse: assert property (iuRespValid |=> !iuRespValid && iuReqReady) else $error("answer pulse wrong");
  a_fetch_hold: assert property (memReq && !memRdValid |=> memReq && $stable(memAddr)) else $error("fetch moved");
  a_walk_answer: assert property ($fell(memReq) && !$past(srst) |-> iuRespValid) else $error("walk end silent");
  a_offset_pass: assert property (iuRespValid && !iuResp.fault |-> iuResp.paddr[11:0] == vaHeld[11:0])
    else $error("offset altered");
  a_fault_kind: assert property (iuRespValid |-> iuResp.fault == (iuResp.kind != mmu_pkg::FAULT_NONE))
    else $error("fault kind mismatch");
  a_miss_busy: assert property ($rose(memReq) |-> !iuReqReady) else $error("walk while idle");
endmodule

bind mmu_tlb_tablewalk mmu_tlb_tablewalk_asserts u_mmu_tlb_tablewalk_asserts (
  .clock(clock), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .iuReqValid(iuReqValid), .iuReq(iuReq), .iuReqReady(iuReqReady),
  .iuRespValid(iuRespValid), .iuResp(iuResp), .memReq(memReq), .memAddr(memAddr), .memRdValid(memRdValid)
);
`default_nettype wire

/* File: dv/mem_table_model.sv */
// Main memory model answering table fetches
`timescale 1ns/1ps
`default_nettype none
module mem_table_model (
  // Clock
  input wire logic   clock,
  // Fetch request
  input wire logic   memReq,
  input wire logic [30:0] memAddr,
  // Fetch answer
  output logic       memRdValid,
  output logic [31:0] memRdData
);
  logic [31:0] words [logic [30:0]];
  logic [30:0] seen [$];
  logic [30:0] lastAddr;
  logic        served;
  int          waitCount;
  int          latency;

  initial begin
    memRdValid = 1'b0;
    memRdData  = 32'h0;
    lastAddr   = 31'h0;
    served     = 1'b0;
    waitCount  = 0;
    latency    = 1;
  end

  // Answer once per stable address; stale data toggles between answers
  always @(posedge clock) begin
    memRdValid <= 1'b0;
    memRdData  <= ~memRdData;
    lastAddr   <= memAddr;
    if (!memReq || memAddr != lastAddr) begin
      waitCount <= 0;
      served    <= 1'b0;
    end else if (!served && waitCount >= latency) begin
      memRdValid <= 1'b1;
      memRdData  <= words.exists(memAddr) ? words[memAddr] : 32'h0;
      served     <= 1'b1;
      seen.push_back(memAddr);
    end else begin
      waitCount <= waitCount + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/mmu_tlb_tablewalk_tb_top.sv */
// Self-checking bench for the translation unit
`timescale 1ns/1ps
`default_nettype none
module mmu_tlb_tablewalk_tb_top;
  localparam logic [5:0] PERM_MAP [8] = '{6'h24, 6'h36, 6'h2d, 6'h3f, 6'h09, 6'h21, 6'h05, 6'h07};
  localparam logic [7:0] ASI_TAB [6] = '{8'h0a, 8'h0a, 8'h08, 8'h0b, 8'h0b, 8'h09};
  logic        clock, srst, hsel, hwrite, hreadyout, hresp, memReq, memRdValid;
  logic        iuReqValid, iuReqReady, iuRespValid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, memRdData, rd;
  logic [30:0] memAddr;
  mmu_pkg::iu_req_t  iuReq;
  mmu_pkg::iu_resp_t iuResp, resp;
  int          err_total, check_count, cycles, base;

  // Design and memory partner
  mmu_tlb_tablewalk u_mmu_tlb_tablewalk (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .iuReqValid(iuReqValid), .iuReq(iuReq), .iuReqReady(iuReqReady), .iuRespValid(iuRespValid),
    .iuResp(iuResp), .memReq(memReq), .memAddr(memAddr), .memRdValid(memRdValid), .memRdData(memRdData));
  mem_table_model u_mem (.clock(clock), .memReq(memReq), .memAddr(memAddr), .memRdValid(memRdValid),
    .memRdData(memRdData));

  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seenVal, input logic [31:0] expVal, input string what);
    check_count++;
    if (seenVal !== expVal) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, expVal, seenVal);
    end
  endtask

  // Single word bus transfer
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (!hreadyout);
    rd = hrdata;
  endtask

  // One translation request and its answer
  task automatic iu(input logic [31:0] va, input logic [7:0] address_space_identifier, input logic wr, input logic [31:0] wd);
    @(posedge clock);
    iuReqValid <= 1'b1;
    iuReq      <= {va, address_space_identifier, wr, wd};
    do @(posedge clock); while (!iuReqReady);
    iuReqValid <= 1'b0;
    do @(posedge clock); while (!iuRespValid);
    resp = iuResp;
  endtask

  task automatic expect_iu(input logic [31:0] va, input logic [7:0] address_space_identifier, input logic wr, input logic [30:0] pa,
                           input logic [1:0] kind);
    iu(va, address_space_identifier, wr, 32'h0);
    check(32'(resp.kind), 32'(kind), "fault kind");
    check(32'(resp.fault), 32'(kind != 2'h0), "fault flag");
    if (kind == 2'h0) check(32'(resp.paddr), 32'(pa), "physical address");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hwdata, iuReqValid, iuReq} = '0;
    hsize = 3'h2;
    {err_total, check_count, cycles} = '0;
    srst = 1'b1;
    u_mem.words[31'h100c] = 32'h201;
    u_mem.words[31'h2048] = 32'h301;
    u_mem.words[31'h3034] = 32'h07ffc006;
    for (int c = 0; c < 8; c++) u_mem.words[31'(32'h2080 + 4 * c)] = 32'(((16 + c) << 20) | (c << 2) | 2);
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    expect_iu(32'h87654321, 8'h0a, 1'b0, 31'h07654321, 2'h0);
    ahb(1'b1, 32'h04, 32'h1000);
    ahb(1'b1, 32'h08, 32'h3);
    ahb(1'b1, 32'h14, 32'hffff);
    ahb(1'b1, 32'h00, 32'h1);
    ahb(1'b0, 32'h04, 32'h0);
    check(rd, 32'h1000, "table pointer");
    ahb(1'b0, 32'h08, 32'h0);
    check(rd, 32'h3, "context");
    ahb(1'b0, 32'h14, 32'h0);
    check(rd, 32'h0, "unmapped read");
    expect_iu(32'h12345678, 8'h0a, 1'b0, 31'h7ffc5678, 2'h0);
    check(32'(u_mem.seen.size()), 32'h3, "walk fetches");
    check(32'(u_mem.seen[0]), 32'h100c, "root fetch");
    check(32'(u_mem.seen[1]), 32'h2048, "level 1 fetch");
    check(32'(u_mem.seen[2]), 32'h3034, "level 2 fetch");
    expect_iu(32'h1237ffff, 8'h0a, 1'b1, 31'h7fffffff, 2'h0);
    check(32'(u_mem.seen.size()), 32'h3, "hit fetches");
    iu(32'h0, 8'h06, 1'b0, 32'h0);
    check(resp.rdata, 32'h01fff019, "modified entry");
    u_mem.latency = 6;
    for (int c = 0; c < 8; c++) begin
      for (int j = 0; j < 6; j++) begin
        expect_iu({8'(32 + c), 24'h000abc}, ASI_TAB[j], j % 3 == 1, 31'(((16 + c) << 24) | 32'habc),
                  PERM_MAP[c][5 - j] ? 2'h0 : 2'h2);
      end
    end
    base = u_mem.seen.size();
    ahb(1'b1, 32'h08, 32'h5);
    expect_iu(32'h27000abc, 8'h0b, 1'b0, 31'h17000abc, 2'h0);
    check(32'(u_mem.seen.size() - base), 32'h0, "supervisor hit fetches");
    expect_iu(32'h21000abc, 8'h0a, 1'b0, 31'h0, 2'h1);
    check(32'(u_mem.seen.size() - base), 32'h1, "context miss fetches");
    ahb(1'b0, 32'h0c, 32'h0);
    check(rd, 32'h0000000a, "status");
    ahb(1'b0, 32'h10, 32'h0);
    check(rd, 32'h21000abc, "fault address");
    ahb(1'b1, 32'h08, 32'h3);
    ahb(1'b1, 32'h00, 32'h3);
    u_mem.latency = 1;
    base = u_mem.seen.size();
    expect_iu(32'h20000abc, 8'h0a, 1'b0, 31'h10000abc, 2'h0);
    check(32'(u_mem.seen.size() - base), 32'h2, "fetches after flush");
    iu(32'h4, 8'h06, 1'b1, 32'h0155aa55);
    iu(32'h4, 8'h06, 1'b0, 32'h0);
    check({7'h0, resp.rdata[24:0]}, 32'h0155aa55, "entry field");
    tally_and_finish();
  end
endmodule
`default_nettype wire
